//--- src/icc_top.sv
// Input capture channel with timer, four-deep buffer and trigger logic
//
// Contract
// - Mode 000 turns channel off
// - Modes 001/010/011: both, falling, rising edges
// - Modes 100/101: every 4th/16th rising edge
// - Mode 111: rising-edge wake interrupt only
// - Mode 110 captures nothing as off, but timer still counts
// - Interrupt every 1 to 4 captures
// - Pacing ignored in modes 001, 111
// - Four-entry capture FIFO
// - Not-empty flag at control one bit 3
// - Overflow flag at bit 4 on full
// - Stop-in-idle halts timer and captures in idle, not the wake interrupt
// - Timer select picks counting clock
// - Own 16-bit counter per channel
// - Cascade needs bit 8 in both halves
// - Bit 7 selects trigger or sync
// - Trigger status gates timer, hold zero
// - Channel rollover acts next cycle
// - Five-bit source select decode
// - Comparator and converter source codes
`timescale 1ns/100ps
module icc_top
    import icc_pkg::*;
#(
    parameter bit UPPER_HALF = 1'b0
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [3:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr_strobe,
    input wire logic rd_strobe,
    output logic [15:0] rdata,
    input wire logic capture_pin,
    input wire logic cpu_idle,
    input wire logic cpu_sleep,
    input wire logic [4:0] general_timer_clock,
    input wire logic [3:0] src_output_compare,
    input wire logic [3:0] src_channel_rollover,
    input wire logic [4:0] src_general_timer,
    input wire logic [3:0] src_capture_int,
    input wire logic [4:0] src_comparator,
    input wire logic src_converter_int,
    input wire logic src_time_measurement_unit,
    input wire logic partner_cascade_enable,
    input wire logic cascade_carry_in,
    output logic cascade_enable_out,
    output logic rollover_out,
    output logic capture_int,
    output logic wake_int
);
    // ---------------------------------------------------------------
    // Source decode
    // ---------------------------------------------------------------
    // Comparator inputs are ordered 1..5 on the bus; codes map 4,5,1,2,3
    function automatic logic src_hit(input logic [4:0] sel);
        logic hit;
        hit = 1'b0;
        case (sel)
            5'h01, 5'h02, 5'h03, 5'h04: hit = src_output_compare[sel[1:0] - 2'h1];
            5'h05, 5'h06, 5'h07, 5'h08: hit = src_channel_rollover[2'(sel - 5'h05)];
            5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h0f: hit = src_general_timer[3'(sel - 5'h0b)];
            5'h10, 5'h11, 5'h12, 5'h13: hit = src_capture_int[sel[1:0]];
            5'h16: hit = src_comparator[3];
            5'h17: hit = src_comparator[4];
            5'h18, 5'h19, 5'h1a: hit = src_comparator[3'(sel - 5'h18)];
            5'h1b: hit = src_converter_int;
            5'h1c: hit = src_time_measurement_unit;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction

    // ---------------------------------------------------------------
    // Register state
    // ---------------------------------------------------------------
    icc_mode_t mode_reg;
    logic [1:0] pace_sel_reg;
    logic [2:0] tsel_reg;
    logic sidl_reg;
    logic ovf_reg;
    logic casc_reg;
    logic trig_mode_reg;
    logic tstat_reg;
    logic [4:0] sel_reg;
    logic [15:0] timer_reg;
    logic pin_prev_reg;
    logic [3:0] presc_reg;
    logic [1:0] pace_reg;
    logic [15:0] fifo_mem [0:3];
    logic [1:0] wr_ptr_reg;
    logic [1:0] rd_ptr_reg;
    logic [2:0] count_reg;

    logic wr_con1, wr_con2, rd_buf;
    logic active, halted, rise, fall, cap_evt, push, pop, src_evt;
    logic clk_tick, tick, cascaded, zero_cond;
    logic [15:0] head;

    assign wr_con1 = wr_strobe && addr == ICC_OFS_CON1;
    assign wr_con2 = wr_strobe && addr == ICC_OFS_CON2;
    assign rd_buf = rd_strobe && addr == ICC_OFS_BUF;
    assign head = fifo_mem[rd_ptr_reg];

    // ---------------------------------------------------------------
    // Edge and capture qualification
    // ---------------------------------------------------------------
    assign halted = sidl_reg && cpu_idle;
    // Off and unused codes both fall out as inactive
    assign active = !halted && mode_reg != ICC_M_OFF && mode_reg != ICC_M_UNUSED;
    assign rise = capture_pin && !pin_prev_reg;
    assign fall = !capture_pin && pin_prev_reg;

    always_comb begin
        cap_evt = 1'b0;
        case (mode_reg)
            ICC_M_BOTH: cap_evt = rise || fall;
            ICC_M_FALL: cap_evt = fall;
            ICC_M_RISE: cap_evt = rise;
            ICC_M_DIV4: cap_evt = rise && presc_reg == ICC_DIV4_LAST;
            ICC_M_DIV16: cap_evt = rise && presc_reg == ICC_DIV16_LAST;
            default: cap_evt = 1'b0;
        endcase
        cap_evt = cap_evt && active;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pin_prev_reg <= 1'b0;
        end else begin
            pin_prev_reg <= capture_pin;
        end
    end

    // Prescaler restarts whenever a non-prescaling mode is chosen
    always_ff @(posedge core_clk) begin
        if (rst) begin
            presc_reg <= 4'h0;
        end else if (mode_reg != ICC_M_DIV4 && mode_reg != ICC_M_DIV16) begin
            presc_reg <= 4'h0;
        end else if (active && rise) begin
            presc_reg <= cap_evt ? 4'h0 : presc_reg + 4'h1;
        end
    end

    // ---------------------------------------------------------------
    // Interrupt pacing and wake output
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pace_reg <= 2'h0;
            capture_int <= 1'b0;
        end else begin
            capture_int <= 1'b0;
            if (!active) begin
                pace_reg <= 2'h0;
            end else if (cap_evt && mode_reg == ICC_M_BOTH) begin
                capture_int <= 1'b1;
            // At-or-above compare: lowering the count mid-run cannot skip an interrupt
            end else if (cap_evt && pace_reg >= pace_sel_reg) begin
                capture_int <= 1'b1;
                pace_reg <= 2'h0;
            end else if (cap_evt) begin
                pace_reg <= pace_reg + 2'h1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            wake_int <= 1'b0;
        end else begin
            wake_int <= mode_reg == ICC_M_WAKE && rise && (cpu_sleep || cpu_idle);
        end
    end

    // ---------------------------------------------------------------
    // Channel timer
    // ---------------------------------------------------------------
    always_comb begin
        case (tsel_reg)
            ICC_TS_PER: clk_tick = 1'b1;
            ICC_TS_T1: clk_tick = general_timer_clock[0];
            ICC_TS_T2: clk_tick = general_timer_clock[1];
            ICC_TS_T3: clk_tick = general_timer_clock[2];
            ICC_TS_T4: clk_tick = general_timer_clock[3];
            ICC_TS_T5: clk_tick = general_timer_clock[4];
            default: clk_tick = 1'b0;
        endcase
    end

    assign cascaded = casc_reg && partner_cascade_enable;
    // Upper half counts lower-half wraps instead of its own clock
    assign tick = !halted && (cascaded && UPPER_HALF ? cascade_carry_in : clk_tick);
    // Procedural so that source pulses read inside the function wake it
    always_comb begin
        src_evt = src_hit(sel_reg);
    end
    assign zero_cond = mode_reg == ICC_M_OFF || (trig_mode_reg && !tstat_reg) || (!trig_mode_reg && src_evt);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            timer_reg <= 16'h0;
            rollover_out <= 1'b0;
        end else begin
            rollover_out <= 1'b0;
            if (zero_cond) begin
                timer_reg <= 16'h0;
            end else if (tick) begin
                timer_reg <= timer_reg + 16'h1;
                rollover_out <= timer_reg == 16'hffff;
            end
        end
    end

    // ---------------------------------------------------------------
    // Capture buffer
    // ---------------------------------------------------------------
    assign push = cap_evt && count_reg != ICC_FIFO_DEPTH;
    assign pop = rd_buf && count_reg != 3'h0;

    always_ff @(posedge core_clk) begin
        if (push) begin
            fifo_mem[wr_ptr_reg] <= timer_reg;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            wr_ptr_reg <= 2'h0;
            rd_ptr_reg <= 2'h0;
            count_reg <= 3'h0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 2'h1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 2'h1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 3'h1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 3'h1;
            end
        end
    end

    // Overflow sticks until the channel is turned off; a new overflow wins
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ovf_reg <= 1'b0;
        end else if (cap_evt && count_reg == ICC_FIFO_DEPTH) begin
            ovf_reg <= 1'b1;
        end else if (mode_reg == ICC_M_OFF) begin
            ovf_reg <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // Control registers
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            mode_reg <= ICC_M_OFF;
            pace_sel_reg <= 2'h0;
            tsel_reg <= ICC_TS_T3;
            sidl_reg <= 1'b0;
        end else if (wr_con1) begin
            mode_reg <= icc_mode_t'(wdata[ICC_C1_MODE_LSB +: 3]);
            pace_sel_reg <= wdata[ICC_C1_PACE_LSB +: 2];
            tsel_reg <= wdata[ICC_C1_TSEL_LSB +: 3];
            sidl_reg <= wdata[ICC_C1_SIDL_BIT];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            casc_reg <= 1'b0;
            trig_mode_reg <= 1'b0;
            sel_reg <= ICC_SEL_RESET;
            cascade_enable_out <= 1'b0;
        end else begin
            if (wr_con2) begin
                casc_reg <= wdata[ICC_C2_CASC_BIT];
                trig_mode_reg <= wdata[ICC_C2_TRIG_BIT];
                sel_reg <= wdata[ICC_C2_SEL_LSB +: 5];
            end
            cascade_enable_out <= wr_con2 ? wdata[ICC_C2_CASC_BIT] : casc_reg;
        end
    end

    // Hardware set beats a software clear in the same cycle
    always_ff @(posedge core_clk) begin
        if (rst) begin
            tstat_reg <= 1'b0;
        end else if (src_evt) begin
            tstat_reg <= 1'b1;
        end else if (wr_con2) begin
            tstat_reg <= wdata[ICC_C2_TSTAT_BIT];
        end
    end

    // ---------------------------------------------------------------
    // Read port
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdata <= 16'h0;
        end else if (rd_strobe) begin
            case (addr)
                ICC_OFS_CON1: rdata <= {2'h0, sidl_reg, tsel_reg, 3'h0, pace_sel_reg, ovf_reg,
                                        count_reg != 3'h0, mode_reg};
                ICC_OFS_CON2: rdata <= {7'h0, casc_reg, trig_mode_reg, tstat_reg, 1'b0, sel_reg};
                ICC_OFS_BUF: rdata <= count_reg != 3'h0 ? head : 16'h0;
                ICC_OFS_TMR: rdata <= timer_reg;
                default: rdata <= 16'h0;
            endcase
        end else begin
            rdata <= 16'h0;
        end
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    a_off_no_push: assert property (@(posedge core_clk) disable iff (rst)
        (mode_reg == ICC_M_OFF || mode_reg == ICC_M_UNUSED) |-> !push)
        else $error("capture pushed while channel off");

    a_rise_capture: assert property (@(posedge core_clk) disable iff (rst)
        (mode_reg == ICC_M_RISE && !halted && rise && count_reg == 3'h0 && !rd_buf) |=> count_reg == 3'h1)
        else $error("rising edge not captured");

    a_wake_no_int: assert property (@(posedge core_clk) disable iff (rst)
        (mode_reg == ICC_M_WAKE) [*2] |-> !capture_int && count_reg == $past(count_reg) - (3'($past(pop))))
        else $error("wake mode captured or interrupted");

    a_pace_every: assert property (@(posedge core_clk) disable iff (rst)
        (cap_evt && mode_reg == ICC_M_RISE && pace_sel_reg == 2'h0) |=> capture_int)
        else $error("capture interrupt missing");

    a_ovf_on_full: assert property (@(posedge core_clk) disable iff (rst)
        (cap_evt && count_reg == ICC_FIFO_DEPTH) |=> ovf_reg && count_reg != 3'h0)
        else $error("overflow not flagged");

    a_bne_clear: assert property (@(posedge core_clk) disable iff (rst)
        (pop && count_reg == 3'h1 && !push) ##1 (rd_strobe && addr == ICC_OFS_CON1) |=> !rdata[ICC_C1_BNE_BIT])
        else $error("not-empty flag still set");

    a_read_oldest: assert property (@(posedge core_clk) disable iff (rst)
        pop |=> rdata == $past(head))
        else $error("buffer read not oldest value");

    a_hold_zero: assert property (@(posedge core_clk) disable iff (rst)
        (trig_mode_reg && !tstat_reg) |=> timer_reg == 16'h0)
        else $error("timer not held at zero");

    a_trig_sets: assert property (@(posedge core_clk) disable iff (rst)
        (src_evt && trig_mode_reg) |=> tstat_reg ##1 (tstat_reg || $past(wr_con2)))
        else $error("trigger did not start timer");

    a_idle_halt: assert property (@(posedge core_clk) disable iff (rst)
        (halted && !zero_cond) |=> $stable(timer_reg) && !capture_int)
        else $error("channel ran in idle");
endmodule

//--- src/icc_pkg.sv
// Constants and types shared by the input capture channel
package icc_pkg;
    // ---------------------------------------------------------------
    // Register offsets
    // ---------------------------------------------------------------
    localparam logic [3:0] ICC_OFS_CON1 = 4'h0;
    localparam logic [3:0] ICC_OFS_CON2 = 4'h1;
    localparam logic [3:0] ICC_OFS_BUF = 4'h2;
    localparam logic [3:0] ICC_OFS_TMR = 4'h3;
    // ---------------------------------------------------------------
    // Control one fields
    // ---------------------------------------------------------------
    localparam int ICC_C1_MODE_LSB = 0;
    localparam int ICC_C1_BNE_BIT = 3;
    localparam int ICC_C1_OVF_BIT = 4;
    localparam int ICC_C1_PACE_LSB = 5;
    localparam int ICC_C1_TSEL_LSB = 10;
    localparam int ICC_C1_SIDL_BIT = 13;
    // ---------------------------------------------------------------
    // Control two fields
    // ---------------------------------------------------------------
    localparam int ICC_C2_SEL_LSB = 0;
    localparam int ICC_C2_TSTAT_BIT = 6;
    localparam int ICC_C2_TRIG_BIT = 7;
    localparam int ICC_C2_CASC_BIT = 8;
    localparam logic [4:0] ICC_SEL_RESET = 5'h0d;
    // ---------------------------------------------------------------
    // Modes and clock selections
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        ICC_M_OFF = 3'h0,
        ICC_M_BOTH = 3'h1,
        ICC_M_FALL = 3'h2,
        ICC_M_RISE = 3'h3,
        ICC_M_DIV4 = 3'h4,
        ICC_M_DIV16 = 3'h5,
        ICC_M_UNUSED = 3'h6,
        ICC_M_WAKE = 3'h7
    } icc_mode_t;
    localparam logic [2:0] ICC_TS_T3 = 3'h0;
    localparam logic [2:0] ICC_TS_T2 = 3'h1;
    localparam logic [2:0] ICC_TS_T4 = 3'h2;
    localparam logic [2:0] ICC_TS_T5 = 3'h3;
    localparam logic [2:0] ICC_TS_T1 = 3'h4;
    localparam logic [2:0] ICC_TS_PER = 3'h7;
    localparam logic [3:0] ICC_DIV4_LAST = 4'h3;
    localparam logic [3:0] ICC_DIV16_LAST = 4'hf;
    localparam logic [2:0] ICC_FIFO_DEPTH = 3'h4;
endpackage

//--- tb/icc_far_side.sv
// Far-side model: capture pin, timer ticks and trigger sources
`timescale 1ns/100ps
module icc_far_side (
    input wire logic core_clk,
    output logic capture_pin,
    output logic [4:0] general_timer_clock,
    output logic [3:0] src_output_compare,
    output logic [3:0] src_channel_rollover,
    output logic [4:0] src_general_timer,
    output logic [3:0] src_capture_int,
    output logic [4:0] src_comparator,
    output logic src_converter_int,
    output logic src_time_measurement_unit
);
    // ---------------------------------------------------------------
    // Idle levels
    // ---------------------------------------------------------------
    task automatic clr;
        capture_pin <= 1'b0;
        general_timer_clock <= '0;
        src_output_compare <= '0;
        src_channel_rollover <= '0;
        src_general_timer <= '0;
        src_capture_int <= '0;
        src_comparator <= '0;
        src_converter_int <= 1'b0;
        src_time_measurement_unit <= 1'b0;
    endtask
    initial clr();
    // ---------------------------------------------------------------
    // Pin and source pulses
    // ---------------------------------------------------------------
    // Rising edges are exactly hi+lo cycles apart
    task automatic pulse(input int hi, input int lo);
        @(posedge core_clk);
        capture_pin <= 1'b1;
        repeat (hi) @(posedge core_clk);
        capture_pin <= 1'b0;
        repeat (lo - 1) @(posedge core_clk);
    endtask
    task automatic tick(input logic [4:0] m);
        @(posedge core_clk);
        general_timer_clock <= m;
        @(posedge core_clk);
        clr();
    endtask
    // Third general timer only pulses when asked; never kept running
    task automatic fire(input logic [4:0] c);
        @(posedge core_clk);
        if (c >= 5'h01 && c <= 5'h04) src_output_compare[int'(c) - 1] <= 1'b1;
        if (c >= 5'h05 && c <= 5'h08) src_channel_rollover[int'(c) - 5] <= 1'b1;
        if (c >= 5'h0b && c <= 5'h0f) src_general_timer[int'(c) - 11] <= 1'b1;
        if (c >= 5'h10 && c <= 5'h13) src_capture_int[int'(c) - 16] <= 1'b1;
        if (c == 5'h16) src_comparator[3] <= 1'b1;
        if (c == 5'h17) src_comparator[4] <= 1'b1;
        if (c >= 5'h18 && c <= 5'h1a) src_comparator[int'(c) - 24] <= 1'b1;
        if (c == 5'h1b) src_converter_int <= 1'b1;
        if (c == 5'h1c) src_time_measurement_unit <= 1'b1;
        @(posedge core_clk);
        clr();
    endtask
    task automatic fire_all;
        @(posedge core_clk);
        src_output_compare <= '1;
        src_channel_rollover <= '1;
        src_general_timer <= '1;
        src_capture_int <= '1;
        src_comparator <= '1;
        src_converter_int <= 1'b1;
        src_time_measurement_unit <= 1'b1;
        @(posedge core_clk);
        clr();
    endtask
endmodule

//--- tb/input_capture_channel_tb_top.sv
// Self-checking testbench for the input capture channel
`timescale 1ns/100ps
module input_capture_channel_tb_top import icc_pkg::*;;
    logic core_clk, rst, wr_strobe, rd_strobe, cpu_idle, cpu_sleep, capture_pin, src_conv, src_tmu;
    logic cascade_enable_out, rollover_out, capture_int, wake_int;
    logic [3:0] addr, src_oc, src_roll, src_cint;
    logic [4:0] gt_clk, src_gt, src_cmp;
    logic [15:0] wdata, rdata;
    int mismatches = 0;
    int n_compared = 0;
    int int_cnt = 0;
    int wake_cnt = 0;
    int roll_cnt = 0;
    icc_top u_dut (.core_clk(core_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_strobe(wr_strobe),
        .rd_strobe(rd_strobe), .rdata(rdata), .capture_pin(capture_pin), .cpu_idle(cpu_idle),
        .cpu_sleep(cpu_sleep), .general_timer_clock(gt_clk), .src_output_compare(src_oc),
        .src_channel_rollover(src_roll), .src_general_timer(src_gt), .src_capture_int(src_cint),
        .src_comparator(src_cmp), .src_converter_int(src_conv), .src_time_measurement_unit(src_tmu),
        .partner_cascade_enable(1'b0), .cascade_carry_in(1'b0), .cascade_enable_out(cascade_enable_out),
        .rollover_out(rollover_out), .capture_int(capture_int), .wake_int(wake_int));
    icc_far_side u_far (.core_clk(core_clk), .capture_pin(capture_pin), .general_timer_clock(gt_clk),
        .src_output_compare(src_oc), .src_channel_rollover(src_roll), .src_general_timer(src_gt),
        .src_capture_int(src_cint), .src_comparator(src_cmp), .src_converter_int(src_conv),
        .src_time_measurement_unit(src_tmu));
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        if (capture_int === 1'b1) int_cnt++;
        if (wake_int === 1'b1) wake_cnt++;
        if (rollover_out === 1'b1) roll_cnt++;
    end
    // ---------------------------------------------------------------
    // Bus and compare helpers
    // ---------------------------------------------------------------
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk);
        addr <= a;
        wdata <= d;
        wr_strobe <= 1'b1;
        @(posedge core_clk);
        wr_strobe <= 1'b0;
    endtask
    // Data stand only in the cycle after the strobe edge
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge core_clk);
        addr <= a;
        rd_strobe <= 1'b1;
        @(posedge core_clk);
        rd_strobe <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic rdchk(input logic [3:0] a, input logic [15:0] exp);
        logic [15:0] v;
        rd(a, v);
        check(v, exp);
    endtask
    // Buffer read then control one read with no gap between the strobes
    task automatic rd_pair(output logic [15:0] b, output logic [15:0] c);
        @(posedge core_clk);
        addr <= ICC_OFS_BUF;
        rd_strobe <= 1'b1;
        @(posedge core_clk);
        addr <= ICC_OFS_CON1;
        #1;
        b = rdata;
        @(posedge core_clk);
        rd_strobe <= 1'b0;
        #1;
        c = rdata;
    endtask
    task automatic drain(output int n);
        logic [15:0] c;
        n = 0;
        for (int i = 0; i < 8; i++) begin
            rd(ICC_OFS_CON1, c);
            if (c[ICC_C1_BNE_BIT] !== 1'b1) break;
            rd(ICC_OFS_BUF, c);
            n++;
        end
    endtask
    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic t_reset;
        rdchk(ICC_OFS_CON1, 16'h0000);
        rdchk(ICC_OFS_CON2, 16'h000d);
        wr(4'h9, 16'hffff);
        rdchk(4'h9, 16'h0000);
        wr(ICC_OFS_CON1, 16'h0018);
        rdchk(ICC_OFS_CON1, 16'h0000);
    endtask
    // Uneven spacing tells a dropped fifth value from an overwritten first
    task automatic t_stamp;
        logic [15:0] s [4];
        logic [15:0] v;
        wr(ICC_OFS_CON1, 16'h1c03);
        for (int i = 0; i < 5; i++) u_far.pulse(3, 7 + i);
        rdchk(ICC_OFS_CON1, 16'h1c1b);
        for (int i = 0; i < 3; i++) rd(ICC_OFS_BUF, s[i]);
        rd_pair(s[3], v);
        for (int i = 1; i < 4; i++) check(s[i] - s[i - 1], 16'(9 + i));
        check(v, 16'h1c13);
        wr(ICC_OFS_CON1, 16'h0000);
        rdchk(ICC_OFS_CON1, 16'h0000);
    endtask
    task automatic t_modes;
        int tab [10][5] = '{'{0, 0, 2, 0, 0}, '{1, 3, 2, 4, 4}, '{2, 0, 2, 2, 2}, '{3, 0, 2, 2, 2},
            '{4, 0, 8, 2, 2}, '{5, 0, 16, 1, 1}, '{6, 0, 2, 0, 0}, '{3, 1, 4, 4, 2}, '{3, 2, 4, 4, 1},
            '{3, 3, 4, 4, 1}};
        int n, c0;
        foreach (tab[k]) begin
            wr(ICC_OFS_CON1, 16'(tab[k][0] + tab[k][1] * 32));
            c0 = int_cnt;
            repeat (tab[k][2]) u_far.pulse(2, 2);
            repeat (3) @(posedge core_clk);
            check(16'(int_cnt - c0), 16'(tab[k][4]));
            drain(n);
            check(16'(n), 16'(tab[k][3]));
            wr(ICC_OFS_CON1, 16'h0000);
        end
    endtask
    task automatic t_idle;
        logic [15:0] a, b;
        int n;
        wr(ICC_OFS_CON1, 16'h3c03);
        @(posedge core_clk);
        cpu_idle <= 1'b1;
        rd(ICC_OFS_TMR, a);
        u_far.pulse(2, 2);
        rd(ICC_OFS_TMR, b);
        check(b, a);
        rdchk(ICC_OFS_CON1, 16'h3c03);
        @(posedge core_clk);
        cpu_idle <= 1'b0;
        u_far.pulse(2, 2);
        rdchk(ICC_OFS_CON1, 16'h3c0b);
        drain(n);
        wr(ICC_OFS_CON1, 16'h0000);
    endtask
    task automatic t_wake;
        int w0, i0;
        wr(ICC_OFS_CON1, 16'h0007);
        @(posedge core_clk);
        cpu_sleep <= 1'b1;
        w0 = wake_cnt;
        i0 = int_cnt;
        u_far.pulse(2, 2);
        @(posedge core_clk);
        cpu_sleep <= 1'b0;
        u_far.pulse(2, 2);
        repeat (2) @(posedge core_clk);
        check(16'(wake_cnt - w0), 16'h0001);
        check(16'(int_cnt - i0), 16'h0000);
        rdchk(ICC_OFS_CON1, 16'h0007);
        wr(ICC_OFS_CON1, 16'h0000);
    endtask
    // Tick bit per select code; 7 marks a reserved code
    task automatic t_tsel;
        logic [2:0] bsel [7] = '{3'd2, 3'd1, 3'd3, 3'd4, 3'd0, 3'd7, 3'd7};
        logic [15:0] t;
        logic [4:0] m;
        rdchk(ICC_OFS_TMR, 16'h0000);
        t = 16'h0000;
        for (int ts = 0; ts < 7; ts++) begin
            m = (bsel[ts] < 3'd5) ? 5'(1 << bsel[ts]) : 5'h00;
            wr(ICC_OFS_CON1, 16'(3 + ts * 1024));
            u_far.tick(~m);
            rdchk(ICC_OFS_TMR, t);
            u_far.tick(m);
            if (m != 5'h00) t = t + 16'h0001;
            rdchk(ICC_OFS_TMR, t);
        end
    endtask
    // Comparator and converter codes used in trigger mode only
    task automatic t_trig;
        // Bench channel stands as the second; its own codes 06 and 11 are never chosen
        logic [4:0] codes [10] = '{5'h01, 5'h05, 5'h0b, 5'h0f, 5'h10, 5'h13, 5'h16, 5'h18, 5'h1b, 5'h1c};
        logic [15:0] t;
        wr(ICC_OFS_CON1, 16'h1c03);
        foreach (codes[k]) begin
            wr(ICC_OFS_CON2, {8'h00, 3'b100, codes[k]});
            rdchk(ICC_OFS_TMR, 16'h0000);
            u_far.fire(codes[k]);
            rdchk(ICC_OFS_CON2, {8'h00, 3'b110, codes[k]});
            rd(ICC_OFS_TMR, t);
            check({15'h0000, t != 16'h0000}, 16'h0001);
        end
        wr(ICC_OFS_CON2, 16'h0080);
        u_far.fire_all();
        rdchk(ICC_OFS_CON2, 16'h0080);
        wr(ICC_OFS_CON2, 16'h00c0);
        rdchk(ICC_OFS_CON2, 16'h00c0);
    endtask
    task automatic t_sync;
        logic [15:0] t;
        int c0;
        wr(ICC_OFS_CON2, 16'h000d);
        repeat (40) @(posedge core_clk);
        rd(ICC_OFS_TMR, t);
        check({15'h0000, t > 16'h0020}, 16'h0001);
        u_far.fire(5'h0d);
        rd(ICC_OFS_TMR, t);
        check({15'h0000, t < 16'h0008}, 16'h0001);
        wr(ICC_OFS_CON2, 16'h010d);
        @(posedge core_clk);
        check({15'h0000, cascade_enable_out}, 16'h0001);
        // Free run from a small value: exactly one wrap in the window
        wr(ICC_OFS_CON2, 16'h00c0);
        c0 = roll_cnt;
        repeat (65540) @(posedge core_clk);
        check(16'(roll_cnt - c0), 16'h0001);
        wr(ICC_OFS_CON1, 16'h0000);
    endtask
    // ---------------------------------------------------------------
    // Run control
    // ---------------------------------------------------------------
    task automatic tally_and_finish;
        $display("Compared %0d values, %0d mismatches", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Whole run is about 70,000 cycles, mostly one timer wrap
    initial begin
        #720000;
        mismatches++;
        tally_and_finish();
    end
    initial begin
        rst <= 1'b1;
        wr_strobe <= 1'b0;
        rd_strobe <= 1'b0;
        cpu_idle <= 1'b0;
        cpu_sleep <= 1'b0;
        addr <= 4'h0;
        wdata <= 16'h0000;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        t_reset();
        t_stamp();
        t_modes();
        t_idle();
        t_wake();
        t_tsel();
        t_trig();
        t_sync();
        tally_and_finish();
    end
endmodule
